// >>> design/ligc_pkg.sv
// Package: constants for the line-interface global control register bank
package ligc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_GLOBAL_CTRL   = 12'hFE1;
    localparam logic [11:0] IDX_CLOCK_RATE    = 12'hFF0;
    localparam logic [11:0] IDX_CHAN_IRQ      = 12'hFF1;
    localparam logic [11:0] IDX_TX_SUPPLY_EN  = 12'hFF2;
    localparam logic [11:0] IDX_RX_SUPPLY_EN  = 12'hFF3;
    localparam logic [11:0] IDX_IRQ_STATUS    = 12'hFF4;
    localparam logic [11:0] IDX_IRQ_MASK      = 12'hFF5;
    localparam logic [13:0] ADDR_GLOBAL_CTRL  = {IDX_GLOBAL_CTRL, 2'b00};
    localparam logic [13:0] ADDR_CLOCK_RATE   = {IDX_CLOCK_RATE, 2'b00};
    localparam logic [13:0] ADDR_CHAN_IRQ     = {IDX_CHAN_IRQ, 2'b00};
    localparam logic [13:0] ADDR_TX_SUPPLY_EN = {IDX_TX_SUPPLY_EN, 2'b00};
    localparam logic [13:0] ADDR_RX_SUPPLY_EN = {IDX_RX_SUPPLY_EN, 2'b00};
    localparam logic [13:0] ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [13:0] ADDR_IRQ_MASK     = {IDX_IRQ_MASK, 2'b00};

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          GLB_TX_EN_BIT   = 7;
    localparam int          GLB_RX_EN_BIT   = 6;
    localparam int          CHAN0_FLAG_BIT  = 0;
    localparam int          EVT_BAD_RATE    = 0;
    localparam int          EVT_CHAN0       = 1;
    localparam int          NUM_CHAN        = 8;
    localparam logic [3:0]  RST_CLOCK_RATE  = 4'h1;
    localparam logic [7:0]  RST_GLOBAL_CTRL = 8'h00;
    localparam logic [7:0]  RST_SUPPLY_EN   = 8'h00;
    localparam logic [1:0]  RST_IRQ         = 2'h0;

    // Decoded master clock rate
    typedef enum logic [2:0] {
        RATE_2048  = 3'b000,
        RATE_1544  = 3'b001,
        RATE_4096  = 3'b010,
        RATE_3088  = 3'b011,
        RATE_8192  = 3'b100,
        RATE_6176  = 3'b101,
        RATE_16384 = 3'b110,
        RATE_12352 = 3'b111
    } ligc_rate_e;

endpackage : ligc_pkg

// >>> design/ligc_regs.sv
// Module: global control register bank of the line-interface section
//
// Overview of operation
// - Select codes decode to eight master clock rates; 0010-0111 reserved.
// - Select field bits 3:0, read/write, resets to 0001; upper bits reserved.
// - Channel 0 interrupt indicator clears when its register is read.
// - Indicator sets on any channel 0 interrupt; reads 0 otherwise.
// - Transmit supply enable: bit n enables channel n, reset 0.
// - Receive supply enable: bit n enables channel n, reset 0.
// - Global transmit supply enable is bit 7 of the global control register.
// - Global receive supply enable is bit 6 of the global control register.
//
// ------------------------------------------------------------------
// Register map (byte address = 4 * index)
// ------------------------------------------------------------------
// Global control     : bits 7 and 6 gate all transmit / receive enables
// Clock rate select  : bits 3:0, decoded one cycle after a write
// Channel indicator  : bit 0, cleared by reading it
// Transmit enables   : one bit per channel
// Receive enables    : one bit per channel
// Interrupt status   : bit 0 reserved-rate event, bit 1 channel 0 event
// Interrupt mask     : same layout as the status register
//
// ------------------------------------------------------------------
// Bus timing
// ------------------------------------------------------------------
// Write address and data are held in one slot each, in either order.
// The response rises one cycle after both slots are full.
// A read is answered at the edge that takes its address.
// Only byte lane 0 carries data; upper read data is always zero.
// Unmapped addresses answer with a slave error and change nothing.
//
// ------------------------------------------------------------------
// Hazards
// ------------------------------------------------------------------
// An event in the cycle of a clear wins, so no event is lost.
// Reserved select codes run the 1.544 rate and raise a status event,
// since a wrong master clock leaves the device unusable.
// Clock enable low freezes everything, bus handshakes included;
// a master must not expect progress while it is low.
//
// ------------------------------------------------------------------
// Side outputs
// ------------------------------------------------------------------
// Decoded rate, reserved flag, gated enables and interrupt all come
// from flip-flops and trail the register write by one cycle.
module ligc_regs
    import ligc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        CE_I,
    input  wire logic        CHAN0_IRQ_I,
    input  wire logic [15:0] S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [15:0] S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic [3:0]       CLOCK_RATE_SEL_O,
    output logic [2:0]       CLOCK_RATE_O,
    output logic             CLOCK_RATE_BAD_O,
    output logic [7:0]       TX_SUPPLY_EN_O,
    output logic [7:0]       RX_SUPPLY_EN_O,
    output logic             IRQ_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             aw_got;
        logic [13:0]      aw_addr;
        logic             w_got;
        logic [7:0]       w_data;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [3:0]       rate_sel;
        logic [7:0]       glb_ctrl;
        logic [7:0]       tx_en;
        logic [7:0]       rx_en;
        logic             chan0_flag;
        logic [1:0]       irq_stat;
        logic [1:0]       irq_mask;
        logic [2:0]       rate;
        logic             rate_bad;
        logic [7:0]       tx_eff;
        logic [7:0]       rx_eff;
        logic             irq;
    } ligc_state_s;

    ligc_state_s s_q;
    ligc_state_s s_d;

    logic       wr_go;
    logic       rd_go;
    logic [1:0] evt;
    logic [7:0] wr_byte;

    // Global gate bits and per-channel gated enables
    logic       glb_tx;
    logic       glb_rx;
    logic [7:0] tx_gate;
    logic [7:0] rx_gate;

    // ------------------------------------------------------------------
    // Rate decode
    // ------------------------------------------------------------------
    // Reserved codes fall back to the reset rate and raise a warning event
    // Codes 1110 and 1111 alias the two lowest rates
    function automatic logic [3:0] decode_rate(input logic [3:0] sel);
        logic [3:0] r;
        r = {1'b0, RATE_1544};
        case (sel)
            4'h0, 4'hE: r = {1'b0, RATE_2048};
            4'h1, 4'hF: r = {1'b0, RATE_1544};
            4'h8:       r = {1'b0, RATE_4096};
            4'h9:       r = {1'b0, RATE_3088};
            4'hA:       r = {1'b0, RATE_8192};
            4'hB:       r = {1'b0, RATE_6176};
            4'hC:       r = {1'b0, RATE_16384};
            4'hD:       r = {1'b0, RATE_12352};
            default:    r = {1'b1, RATE_1544};
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Write fires once both address and data have been captured
    assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign rd_go = S_AXI_ARVALID_I && !s_q.rvalid;
    assign wr_byte = s_q.w_data;

    // ------------------------------------------------------------------
    // Per-channel enable gating
    // ------------------------------------------------------------------
    // A global bit gates all eight channels at once, so software can stop
    // every channel without rewriting the per-channel bits
    assign glb_tx = s_q.glb_ctrl[GLB_TX_EN_BIT];
    assign glb_rx = s_q.glb_ctrl[GLB_RX_EN_BIT];

    // One transmit and one receive gate per channel
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        assign tx_gate[ch] = s_q.tx_en[ch] & glb_tx;
        assign rx_gate[ch] = s_q.rx_en[ch] & glb_rx;
    end

    always_comb begin
        logic [3:0] dec;
        dec = decode_rate(s_q.rate_sel);
        evt = '0;
        s_d = s_q;

        // Address and data channels accepted in either order
        if (S_AXI_AWVALID_I && !s_q.aw_got) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = S_AXI_AWADDR_I[13:0];  // Byte address, top ignored
        end
        if (S_AXI_WVALID_I && !s_q.w_got) begin
            s_d.w_got   = 1'b1;
            s_d.w_data  = S_AXI_WDATA_I[7:0];
            s_d.w_lane0 = S_AXI_WSTRB_I[0];
        end
        if (s_q.bvalid && S_AXI_BREADY_I) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && S_AXI_RREADY_I) begin
            s_d.rvalid = 1'b0;
        end

        // Register writes; only byte lane 0 carries data
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            case (s_q.aw_addr)
                // Only bits 7 and 6 act; the rest are plain storage
                ADDR_GLOBAL_CTRL: begin
                    if (s_q.w_lane0) s_d.glb_ctrl = wr_byte;
                end
                ADDR_CLOCK_RATE: begin
                    if (s_q.w_lane0) s_d.rate_sel = wr_byte[3:0];
                end
                ADDR_CHAN_IRQ: begin
                    // Read-only; writes dropped
                end
                ADDR_TX_SUPPLY_EN: begin
                    if (s_q.w_lane0) s_d.tx_en = wr_byte;
                end
                ADDR_RX_SUPPLY_EN: begin
                    if (s_q.w_lane0) s_d.rx_en = wr_byte;
                end
                // Write one to clear; an event in the same cycle still wins
                ADDR_IRQ_STATUS: begin
                    if (s_q.w_lane0) s_d.irq_stat = s_q.irq_stat & ~wr_byte[1:0];
                end
                // Mask bits let each event reach the interrupt line
                ADDR_IRQ_MASK: begin
                    if (s_q.w_lane0) s_d.irq_mask = wr_byte[1:0];
                end
                default: s_d.bresp = 2'b10;  // SLVERR on unmapped address
            endcase
        end

        // Reads; indicator self-clears on read of its register
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            s_d.rdata  = '0;
            case (S_AXI_ARADDR_I[13:0])
                ADDR_GLOBAL_CTRL:  s_d.rdata[7:0] = s_q.glb_ctrl;
                ADDR_CLOCK_RATE:   s_d.rdata[3:0] = s_q.rate_sel;
                ADDR_CHAN_IRQ: begin
                    s_d.rdata[CHAN0_FLAG_BIT] = s_q.chan0_flag;
                    s_d.chan0_flag = 1'b0;
                end
                ADDR_TX_SUPPLY_EN: s_d.rdata[7:0] = s_q.tx_en;
                ADDR_RX_SUPPLY_EN: s_d.rdata[7:0] = s_q.rx_en;
                ADDR_IRQ_STATUS:   s_d.rdata[1:0] = s_q.irq_stat;
                ADDR_IRQ_MASK:     s_d.rdata[1:0] = s_q.irq_mask;
                default:           s_d.rresp      = 2'b10;
            endcase
        end

        // Events win over a clear in the same cycle
        evt[EVT_CHAN0]    = CHAN0_IRQ_I;
        evt[EVT_BAD_RATE] = dec[3] && !s_q.rate_bad;
        if (CHAN0_IRQ_I) s_d.chan0_flag = 1'b1;
        s_d.irq_stat = s_d.irq_stat | evt;

        // Registered outputs follow the programmed state
        s_d.rate     = dec[2:0];
        s_d.rate_bad = dec[3];
        s_d.tx_eff   = tx_gate;
        s_d.rx_eff   = rx_gate;
        s_d.irq      = |(s_q.irq_stat & s_q.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Clock enable freezes the whole bank, bus handshakes included
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s_q          <= '0;
            s_q.rate_sel <= RST_CLOCK_RATE;
            s_q.glb_ctrl <= RST_GLOBAL_CTRL;
            s_q.tx_en    <= RST_SUPPLY_EN;
            s_q.rx_en    <= RST_SUPPLY_EN;
            s_q.irq_stat <= RST_IRQ;
            s_q.irq_mask <= RST_IRQ;
            s_q.rate     <= RATE_1544;
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Ready is high while the channel's holding slot is empty
    assign S_AXI_AWREADY_O  = !s_q.aw_got;
    assign S_AXI_WREADY_O   = !s_q.w_got;
    // Responses stand until the master takes them
    assign S_AXI_BVALID_O   = s_q.bvalid;
    assign S_AXI_BRESP_O    = s_q.bresp;
    assign S_AXI_ARREADY_O  = !s_q.rvalid;
    assign S_AXI_RVALID_O   = s_q.rvalid;
    assign S_AXI_RDATA_O    = s_q.rdata;
    assign S_AXI_RRESP_O    = s_q.rresp;

    // Side outputs for the line-interface logic
    assign CLOCK_RATE_SEL_O = s_q.rate_sel;
    assign CLOCK_RATE_O     = s_q.rate;
    assign CLOCK_RATE_BAD_O = s_q.rate_bad;
    assign TX_SUPPLY_EN_O   = s_q.tx_eff;
    assign RX_SUPPLY_EN_O   = s_q.rx_eff;

    // Level interrupt, high while an unmasked status bit is set
    assign IRQ_O            = s_q.irq;

endmodule // ligc_regs

// >>> tb/ligc_asserts.sv
// Checker: rate decode, write timing and read answers of the register bank
module ligc_asserts
    import ligc_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    input wire logic        CE_I,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic [3:0]  CLOCK_RATE_SEL_O,
    input wire logic [2:0]  CLOCK_RATE_O,
    input wire logic        CLOCK_RATE_BAD_O,
    input wire logic [7:0]  TX_SUPPLY_EN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rate_low: assert property (
        CE_I && CLOCK_RATE_SEL_O inside {4'h0, 4'hE} |=> CLOCK_RATE_O == 3'h0)
        else $error("low select code decoded wrongly");
    a_rate_high: assert property (
        CE_I && CLOCK_RATE_SEL_O inside {[4'h8:4'hD]}
        |=> CLOCK_RATE_O == $past(CLOCK_RATE_SEL_O[2:0]) + 3'h2)
        else $error("high select code decoded wrongly");
    // The flag may trail the select by a cycle, so either value may hold it
    a_bad_flag: assert property (
        CLOCK_RATE_BAD_O |-> CLOCK_RATE_SEL_O inside {[4'h2:4'h7]}
        || $past(CLOCK_RATE_SEL_O) inside {[4'h2:4'h7]})
        else $error("reserved flag without reserved select");
    a_sel_reset: assert property (
        $rose(RST_B_I) |-> CLOCK_RATE_SEL_O == 4'h1)
        else $error("select not at its reset code");
    a_sel_by_write: assert property (
        $changed(CLOCK_RATE_SEL_O) |-> $past(S_AXI_WVALID_I && S_AXI_WREADY_O)
        || $past(S_AXI_WVALID_I && S_AXI_WREADY_O, 2))
        else $error("select moved without a write");
    a_tx_by_write: assert property (
        $changed(TX_SUPPLY_EN_O) |-> $past(S_AXI_WVALID_I && S_AXI_WREADY_O, 2)
        || $past(S_AXI_WVALID_I && S_AXI_WREADY_O, 3))
        else $error("transmit enables moved without a write");
    a_read_answer: assert property (
        CE_I && S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read not answered next cycle");
    a_upper_zero: assert property (
        S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("upper read data not zero");
    c_bad: cover property ($rose(CLOCK_RATE_BAD_O));
    c_flag: cover property (S_AXI_RVALID_O && S_AXI_RDATA_O[0]);
    c_tx: cover property (TX_SUPPLY_EN_O != 8'h00);
endmodule // ligc_asserts

bind ligc_regs ligc_asserts u_chk (.*);

// >>> tb/tb.sv
// Testbench: bus access, rate decode, enables and interrupt of the bank
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    n_fail++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end
module tb
    import ligc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals carry the port names so the instance connects by name
    // ------------------------------------------------------------------
    logic CLK_I = 1'h0, RST_B_I = 1'h0, CE_I = 1'h1, CHAN0_IRQ_I = 1'h0;
    logic S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
    logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0;
    logic [15:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
    logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O, seed = 32'h26, t;
    logic [3:0]  S_AXI_WSTRB_I = 4'hF, CLOCK_RATE_SEL_O;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
    logic S_AXI_RVALID_O, CLOCK_RATE_BAD_O, IRQ_O;
    logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic [2:0]  CLOCK_RATE_O;
    logic [7:0]  TX_SUPPLY_EN_O, RX_SUPPLY_EN_O;
    logic [33:0] exp_q[$], ex_v;
    logic [1:0]  bexp_q[$], eb;
    int n_fail = 0, total_checks = 0, cyc = 0;
    // Expected decoded rate per select code, code 0 in the low bits
    localparam logic [47:0] RATE_TAB = {3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h4,
        3'h3, 3'h2, {7{3'h1}}, 3'h0};

    ligc_regs uut (.*);

    always #2 CLK_I = ~CLK_I; // 250 MHz

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Bus tasks: address and data offered together, held until taken
    // ------------------------------------------------------------------
    task automatic wr(input logic [13:0] a, input logic [7:0] d,
                      input logic [1:0] er = 2'h0);
        @(posedge CLK_I);
        bexp_q.push_back(er);
        S_AXI_AWADDR_I <= {2'h0, a};
        S_AXI_WDATA_I <= {24'h0, d};
        S_AXI_AWVALID_I <= 1'h1;
        S_AXI_WVALID_I <= 1'h1;
        S_AXI_BREADY_I <= 1'h1;
        do begin
            @(posedge CLK_I);
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
        end while (!S_AXI_BVALID_O);
        S_AXI_BREADY_I <= 1'h0;
    endtask

    // The expected answer is queued here and judged by the watcher below
    task automatic rd(input logic [13:0] a, input logic [33:0] ex);
        @(posedge CLK_I);
        exp_q.push_back(ex);
        S_AXI_ARADDR_I <= {2'h0, a};
        S_AXI_ARVALID_I <= 1'h1;
        S_AXI_RREADY_I <= 1'h1;
        do begin
            @(posedge CLK_I);
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'h0;
        end while (!S_AXI_RVALID_O);
        S_AXI_RREADY_I <= 1'h0;
    endtask

    // Read and write response watcher and hang limit
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            ex_v = exp_q.pop_front();
            `CHK("read", ex_v, {S_AXI_RRESP_O, S_AXI_RDATA_O})
        end
        if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            eb = bexp_q.pop_front();
            `CHK("wresp", eb, S_AXI_BRESP_O)
        end
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge CLK_I);
        RST_B_I <= 1'h1;
        rd(ADDR_CLOCK_RATE, 34'h1);
        rd(ADDR_CHAN_IRQ, 34'h0);
        rd(ADDR_TX_SUPPLY_EN, 34'h0);
        rd(ADDR_RX_SUPPLY_EN, 34'h0);
        $display("test reset values done");
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_CLOCK_RATE, 8'(c));
            repeat (2) @(posedge CLK_I);
            `CHK("rate", RATE_TAB[c*3 +: 3], CLOCK_RATE_O)
            `CHK("bad", 1'(c >= 2 && c <= 7), CLOCK_RATE_BAD_O)
        end
        rd(ADDR_CLOCK_RATE, 34'hF);
        $display("test rate decode done");
        // Global bits walk all four combinations over random channel bits
        for (int i = 0; i < 4; i++) begin
            t = xs();
            wr(ADDR_TX_SUPPLY_EN, t[7:0]);
            wr(ADDR_RX_SUPPLY_EN, t[15:8]);
            wr(ADDR_GLOBAL_CTRL, {i[1], i[0], 6'h0});
            repeat (2) @(posedge CLK_I);
            `CHK("tx", i[1] ? t[7:0] : 8'h0, TX_SUPPLY_EN_O)
            `CHK("rx", i[0] ? t[15:8] : 8'h0, RX_SUPPLY_EN_O)
            rd(ADDR_RX_SUPPLY_EN, {26'h0, t[15:8]});
        end
        $display("test enables done");
        wr(ADDR_IRQ_STATUS, 8'h3);
        wr(ADDR_IRQ_MASK, 8'h2);
        CHAN0_IRQ_I <= 1'h1;
        @(posedge CLK_I);
        CHAN0_IRQ_I <= 1'h0;
        repeat (3) @(posedge CLK_I);
        `CHK("irq", 1'h1, IRQ_O)
        rd(ADDR_CHAN_IRQ, 34'h1);
        rd(ADDR_CHAN_IRQ, 34'h0);
        wr(ADDR_CHAN_IRQ, 8'hFF);
        rd(ADDR_CHAN_IRQ, 34'h0);
        wr(ADDR_IRQ_MASK, 8'h0);
        repeat (2) @(posedge CLK_I);
        `CHK("masked", 1'h0, IRQ_O)
        wr(ADDR_IRQ_MASK, 8'h2);
        repeat (2) @(posedge CLK_I);
        `CHK("sticky", 1'h1, IRQ_O)
        wr(ADDR_IRQ_STATUS, 8'h2);
        repeat (2) @(posedge CLK_I);
        `CHK("cleared", 1'h0, IRQ_O)
        $display("test interrupt done");
        // Events while the clock enable is low must leave no trace
        CE_I <= 1'h0;
        CHAN0_IRQ_I <= 1'h1;
        repeat (2) @(posedge CLK_I);
        CE_I <= 1'h1;
        CHAN0_IRQ_I <= 1'h0;
        `CHK("frozen", 1'h0, IRQ_O)
        rd(ADDR_CHAN_IRQ, 34'h0);
        rd(ADDR_IRQ_STATUS, 34'h0);
        $display("test clock enable done");
        wr(14'h0, 8'h5, 2'h2);
        rd(14'h0, {2'h2, 32'h0});
        $display("test unmapped done");
        summarize();
    end
endmodule // tb
